// ---- src/wdt_timeout_unit.v ----
// Purpose: watchdog time-out unit with timed-access protection
// Assumes: one clock, 8-bit register port, read data one cycle later
// Notes:   counts clk_in cycles directly
//
// Function
// R01 - free-running counter, flag at period, restartable
// R02 - period select in clock control bits 7:6
// R03 - periods 2^17/20/23/26, reset adds 512
// R04 - interrupt flag 512 clocks before reset flag
// R05 - enabled reset time-out resets the CPU
// R06 - enable and restart need timed-access sequence
// R07 - interrupt request only when source enabled
// R08 - interrupt serves as time base and wake-up
// R09 - periods counted in crystal clock cycles
// R10 - restart clears counter and all progress
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "wdt_defs.vh"

module wdt_timeout_unit #(
  parameter integer EXP0 = `WDT_EXP0,
  parameter integer EXP1 = `WDT_EXP1,
  parameter integer EXP2 = `WDT_EXP2,
  parameter integer EXP3 = `WDT_EXP3
) (
  input  wire       clk_in,
  input  wire       resetn_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  output wire       irq_out,
  output wire       wdt_irq_req_out,
  output wire       wake_out,
  output reg        cpu_rst_out
);

  // ----------------------------------------
  // timed-access states
  // ----------------------------------------
  localparam [1:0] TA_IDLE = 2'h0;
  localparam [1:0] TA_KEY1 = 2'h1;
  localparam [1:0] TA_OPEN = 2'h2;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  function [26:0] int_lim;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: int_lim = `WDT_CNT_ONE << EXP0;
        2'h1: int_lim = `WDT_CNT_ONE << EXP1;
        2'h2: int_lim = `WDT_CNT_ONE << EXP2;
        default: int_lim = `WDT_CNT_ONE << EXP3;
      endcase
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg  [7:0]  clkspd_r;
  reg  [7:0]  clkspd_nxt;
  reg  [7:4]  wdhi_r;
  reg  [7:4]  wdhi_nxt;
  reg         wdif_r;
  reg         wdif_nxt;
  reg         wtrf_r;
  reg         wtrf_nxt;
  reg         ewt_r;
  reg         ewt_nxt;
  reg  [7:0]  irqen_r;
  reg  [7:0]  irqen_nxt;
  reg  [1:0]  stat_r;
  wire [1:0]  stat_nxt;
  reg  [1:0]  mask_r;
  reg  [1:0]  mask_nxt;
  reg  [26:0] cnt_r;
  reg  [26:0] cnt_nxt;
  reg  [1:0]  ta_r;
  reg  [1:0]  ta_nxt;
  reg  [1:0]  ta_cnt_r;
  reg  [1:0]  ta_cnt_nxt;
  reg  [7:0]  rdata_nxt;
  wire [1:0]  sel;
  wire [26:0] lim_int;
  wire [26:0] lim_rst;
  wire        int_hit;
  wire        rst_hit;
  wire        ta_open;
  wire        wr_wdctl;
  wire        wr_clkspd;
  wire        wr_irqen;
  wire        wr_mask;
  wire        wr_tacc;
  wire        wr_stat;
  wire        restart;
  wire [1:0]  events;
  wire [1:0]  clr_bits;
  wire        cpu_rst_nxt;

  // ----------------------------------------
  // period decode
  // ----------------------------------------
  assign sel = {clkspd_r[`WDT_SEL_HI],
                clkspd_r[`WDT_SEL_LO]}; // R02

  assign lim_int = int_lim(sel); // R03
  assign lim_rst = lim_int + `WDT_RST_EXTRA; // R03

  // compare on clk_in counts only
  assign int_hit = (cnt_r == lim_int); // R01 R09
  assign rst_hit = (cnt_r == lim_rst); // R04

  // ----------------------------------------
  // timed access
  // ----------------------------------------
  assign ta_open  = (ta_r == TA_OPEN);
  assign wr_wdctl = wr_in & hit(addr_in, `WDT_A_WDCTL);
  assign wr_tacc  = wr_in & hit(addr_in, `WDT_A_TACC);
  assign restart  = wr_wdctl & ta_open & wdata_in[`WDT_WC_RS]; // R06

  always @* begin
    ta_nxt     = ta_r;
    ta_cnt_nxt = ta_cnt_r;
    case (ta_r)
      TA_IDLE: begin
        if (wr_tacc && wdata_in == `WDT_TA_KEY1) begin
          ta_nxt = TA_KEY1;
        end
      end
      TA_KEY1: begin
        // any other write aborts; reads and idle cycles do not
        if (wr_in) begin
          if (wr_tacc && wdata_in == `WDT_TA_KEY2) begin
            ta_nxt     = TA_OPEN; // R06
            ta_cnt_nxt = `WDT_TA_WIN;
          end else begin
            ta_nxt = TA_IDLE;
          end
        end
      end
      TA_OPEN: begin
        // window closes on the protected write or after a few cycles
        ta_cnt_nxt = ta_cnt_r - `WDT_TA_STEP;
        if (wr_wdctl || ta_cnt_r == `WDT_TA_STEP) begin
          ta_nxt = TA_IDLE;
        end
      end
      default: begin
        ta_nxt = TA_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // wraps after the reset time-out so the watchdog keeps running;
  // a period cut below the current count waits for the 27-bit wrap
  always @* begin
    if (restart) begin
      cnt_nxt = `WDT_CNT_ZERO; // R10
    end else if (rst_hit) begin
      cnt_nxt = `WDT_CNT_ZERO; // R01
    end else begin
      cnt_nxt = cnt_r + `WDT_CNT_ONE; // R01 R09
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  assign wr_clkspd = wr_in & hit(addr_in, `WDT_A_CLKSPD);
  assign wr_irqen  = wr_in & hit(addr_in, `WDT_A_IRQEN);
  assign wr_mask   = wr_in & hit(addr_in, `WDT_A_MASK);

  always @* begin
    clkspd_nxt = clkspd_r;
    wdhi_nxt   = wdhi_r;
    ewt_nxt    = ewt_r;
    irqen_nxt  = irqen_r;
    mask_nxt   = mask_r;
    wdif_nxt   = wdif_r;
    wtrf_nxt   = wtrf_r;
    if (wr_clkspd) begin
      clkspd_nxt = wdata_in; // R02
    end
    if (wr_irqen) begin
      irqen_nxt = wdata_in; // R07
    end
    if (wr_mask) begin
      mask_nxt = wdata_in[`WDT_ST_ALL];
    end
    if (wr_wdctl) begin
      wdhi_nxt = wdata_in[`WDT_WC_HI];
      wdif_nxt = wdata_in[`WDT_WC_IF];
      wtrf_nxt = wdata_in[`WDT_WC_RF];
      if (ta_open) begin
        ewt_nxt = wdata_in[`WDT_WC_EN]; // R06
      end
    end
    // hardware set wins over a software clear
    if (int_hit && !restart) begin
      wdif_nxt = 1'b1; // R01 R04
    end
    if (rst_hit && !restart) begin
      wtrf_nxt = 1'b1; // R04
    end
  end

  // ----------------------------------------
  // sticky status, write one to clear
  // ----------------------------------------
  assign wr_stat  = wr_in & hit(addr_in, `WDT_A_STAT);
  // events that meet a restart are dropped with the rest of the progress
  assign events   = {rst_hit & ~restart, int_hit & ~restart};
  assign clr_bits = wr_stat ? wdata_in[`WDT_ST_ALL] : `WDT_RST2;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_stat
      assign stat_nxt[gi] = events[gi] | (stat_r[gi] & ~clr_bits[gi]);
    end
  endgenerate

  assign irq_out = |(stat_r & mask_r);

  // ----------------------------------------
  // interrupt system and wake-up
  // ----------------------------------------
  assign wdt_irq_req_out = wdif_r & irqen_r[`WDT_IE_WDI]; // R07
  assign wake_out        = wdt_irq_req_out; // R08

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // read data is zero outside the cycle after a read
  always @* begin
    rdata_nxt = `WDT_RST8;
    if (rd_in) begin
      case (addr_in)
        `WDT_A_CLKSPD: rdata_nxt = clkspd_r;
        `WDT_A_WDCTL:  rdata_nxt = {wdhi_r, wdif_r, wtrf_r, ewt_r, 1'b0};
        `WDT_A_IRQEN:  rdata_nxt = irqen_r;
        `WDT_A_STAT:   rdata_nxt = {`WDT_PAD6, stat_r};
        `WDT_A_MASK:   rdata_nxt = {`WDT_PAD6, mask_r};
        default:       rdata_nxt = `WDT_RST8;
      endcase
    end
  end

  // ----------------------------------------
  // cpu reset request
  // ----------------------------------------
  // one-cycle request; a coincident restart cancels it
  assign cpu_rst_nxt = rst_hit & ewt_r & ~restart; // R05

  // ----------------------------------------
  // flip-flops
  // ----------------------------------------
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clkspd_r    <= `WDT_RST8;
      wdhi_r      <= `WDT_RST4;
      wdif_r      <= 1'b0;
      wtrf_r      <= 1'b0;
      ewt_r       <= 1'b0;
      irqen_r     <= `WDT_RST8;
      stat_r      <= `WDT_RST2;
      mask_r      <= `WDT_RST2;
      cnt_r       <= `WDT_CNT_ZERO;
      ta_r        <= TA_IDLE;
      ta_cnt_r    <= `WDT_RST2;
      rdata_out   <= `WDT_RST8;
      cpu_rst_out <= 1'b0;
    end else begin
      clkspd_r    <= clkspd_nxt;
      wdhi_r      <= wdhi_nxt;
      wdif_r      <= wdif_nxt;
      wtrf_r      <= wtrf_nxt;
      ewt_r       <= ewt_nxt;
      irqen_r     <= irqen_nxt;
      stat_r      <= stat_nxt;
      mask_r      <= mask_nxt;
      cnt_r       <= cnt_nxt;
      ta_r        <= ta_nxt;
      ta_cnt_r    <= ta_cnt_nxt;
      rdata_out   <= rdata_nxt;
      cpu_rst_out <= cpu_rst_nxt; // R05
    end
  end

endmodule // wdt_timeout_unit

// ---- src/wdt_defs.vh ----
// Purpose: constants of the watchdog time-out unit
// Assumes: 8-bit special-function-register port
// Notes:   definitions only
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define WDT_A_CLKSPD   8'h8e
`define WDT_A_WDCTL    8'hd8
`define WDT_A_IRQEN    8'he8
`define WDT_A_TACC     8'hc7
`define WDT_A_STAT     8'hf9
`define WDT_A_MASK     8'hfa

// ----------------------------------------
// field positions
// ----------------------------------------
`define WDT_SEL_HI     7
`define WDT_SEL_LO     6
`define WDT_WC_IF      3
`define WDT_WC_RF      2
`define WDT_WC_EN      1
`define WDT_WC_RS      0
`define WDT_IE_WDI     6
`define WDT_ST_INT     0
`define WDT_ST_RST     1
`define WDT_WC_HI      7:4
`define WDT_ST_ALL     1:0

// ----------------------------------------
// reset values and keys
// ----------------------------------------
`define WDT_RST8       8'h00
`define WDT_RST2       2'h0
`define WDT_RST4       4'h0
`define WDT_PAD6       6'h00
`define WDT_TA_STEP    2'h1
`define WDT_TA_KEY1    8'haa
`define WDT_TA_KEY2    8'h55
`define WDT_TA_WIN     2'h3

// ----------------------------------------
// time-out figures in clocks
// ----------------------------------------
`define WDT_EXP0       17
`define WDT_EXP1       20
`define WDT_EXP2       23
`define WDT_EXP3       26
`define WDT_RST_EXTRA  27'h200
`define WDT_CNT_ONE    27'h1
`define WDT_CNT_ZERO   27'h0

`endif

// ---- verif/wdt_timeout_unit_properties.sv ----
// Purpose: port assertions for the watchdog unit
// Assumes: bound into wdt_timeout_unit
// Notes:   register port and output relations only
`timescale 1ns/1ps
module wdt_props (
  input wire       clk_in,
  input wire       resetn_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  input wire       irq_out,
  input wire       wdt_irq_req_out,
  input wire       wake_out,
  input wire       cpu_rst_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ----
  // sequences and assertions
  // ----
  sequence s_wr(a, d);
    wr_in && addr_in == a && wdata_in == d;
  endsequence
  sequence s_restart;
    s_wr(8'hc7, 8'haa) ##1 s_wr(8'hc7, 8'h55) ##1 (wr_in && addr_in == 8'hd8 && wdata_in[0]);
  endsequence
  a_wake_follows_req: assert property (wake_out == wdt_irq_req_out)
    else $error("wake differs from request");
  a_rst_one_pulse: assert property (cpu_rst_out |=> !cpu_rst_out)
    else $error("reset pulse too long");
  a_restart_quiet: assert property (s_restart |=> ##2 !cpu_rst_out [*8])
    else $error("reset right after restart");
  a_req_needs_en: assert property (wr_in && addr_in == 8'he8 && !wdata_in[6] |=> !wdt_irq_req_out)
    else $error("request without enable");
  a_mask_off_quiet: assert property (s_wr(8'hfa, 8'h00) |=> !irq_out)
    else $error("irq with all masked");
  a_period_readback: assert property ((wr_in && addr_in == 8'h8e) ##1
    (rd_in && addr_in == 8'h8e) |=> rdata_out == $past(wdata_in, 2))
    else $error("period select readback");
  a_restart_reads0: assert property (rd_in && addr_in == 8'hd8 |=> !rdata_out[0])
    else $error("restart bit reads one");
  a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data without read");
endmodule // wdt_props
bind wdt_timeout_unit wdt_props wdt_props_i (
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
  .wdt_irq_req_out(wdt_irq_req_out), .wake_out(wake_out), .cpu_rst_out(cpu_rst_out));

// ---- verif/watchdog_timeout_unit_test.sv ----
// Purpose: self-checking bench for the watchdog unit
// Assumes: periods shortened to 2^4..2^7
// Notes:   bench drives the register port
`timescale 1ns/1ps
module watchdog_timeout_unit_test;
  reg        clk_in, resetn_in, wr_in, rd_in;
  reg  [7:0] addr_in, wdata_in;
  wire [7:0] rdata_out;
  wire       irq_out, req, wake, rst;
  integer    bad_count, num_checks, n, m, s;
  wdt_timeout_unit #(.EXP0(4), .EXP1(5), .EXP2(6), .EXP3(7)) wdt_timeout_unit_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .wdt_irq_req_out(req), .wake_out(wake), .cpu_rst_out(rst));
  // ----
  // check and bus tasks
  // ----
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      rd_in    <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] k, input [7:0] e);
    begin
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      wr_in   <= 1'b0;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out & k, e);
    end
  endtask
  task idle;
    begin
      @(posedge clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      #1;
    end
  endtask
  task ta(input [7:0] d);
    begin
      wr(8'hc7, 8'haa);
      wr(8'hc7, 8'h55);
      wr(8'hd8, d);
      idle;
    end
  endtask
  // ----
  // scenarios and verdict
  // ----
  task t_regs;
    begin
      rd(8'h8e, 8'hff, 8'h00);
      rd(8'he8, 8'hff, 8'h00);
      rd(8'hfa, 8'hff, 8'h00);
      rd(8'h00, 8'hff, 8'h00);
      wr(8'h8e, 8'hff);
      rd(8'h8e, 8'hff, 8'hff);
      wr(8'hd8, 8'h03);
      rd(8'hd8, 8'h03, 8'h00);
      ta(8'h02);
      rd(8'hd8, 8'h03, 8'h02);
      ta(8'h00);
    end
  endtask
  task t_period;
    begin
      for (s = 0; s < 4; s = s + 1) begin
        wr(8'h8e, {s[1:0], 6'h00});
        wr(8'he8, 8'h40);
        wr(8'hfa, 8'h03);
        wr(8'hf9, 8'h03);
        ta(8'h03);
        n = 0;
        while (req !== 1'b1 && n < 300) begin
          @(posedge clk_in);
          #1;
          n = n + 1;
        end
        chk(n >= (16 << s) && n <= (16 << s) + 2, 1);
        chk(irq_out, 1);
        m = 0;
        while (rst !== 1'b1 && m < 600) begin
          @(posedge clk_in);
          #1;
          m = m + 1;
        end
        chk(m >= 512 && m <= 513, 1);
        rd(8'hf9, 8'h03, 8'h03);
      end
    end
  endtask
  task t_mask;
    begin
      wr(8'hfa, 8'h00);
      idle;
      chk(irq_out, 0);
      wr(8'hfa, 8'h01);
      idle;
      chk(irq_out, 1);
      wr(8'hf9, 8'h01);
      idle;
      chk(irq_out, 0);
      wr(8'he8, 8'h00);
      idle;
      chk(req, 0);
      wr(8'he8, 8'h40);
      idle;
      chk(req, 1);
      chk(wake, 1);
    end
  endtask
  task t_restart;
    begin
      wr(8'h8e, 8'h00);
      repeat (6) begin
        ta(8'h03);
        repeat (8) @(posedge clk_in);
      end
      #1;
      chk(req, 0);
      wr(8'hd8, 8'h01);
      idle;
      repeat (20) @(posedge clk_in);
      #1;
      chk(req, 1);
      wr(8'hf9, 8'h03);
      ta(8'h01);
      m = 0;
      while (rst !== 1'b1 && m < 600) begin
        @(posedge clk_in);
        #1;
        m = m + 1;
      end
      chk(m, 600);
      rd(8'hf9, 8'h02, 8'h02);
    end
  endtask
  task give_verdict;
    begin
      if (bad_count == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    bad_count  = 0;
    num_checks = 0;
    resetn_in  = 1'b0;
    wr_in      = 1'b0;
    rd_in      = 1'b0;
    addr_in    = 8'h00;
    wdata_in   = 8'h00;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_regs;
    t_period;
    t_mask;
    t_restart;
    give_verdict;
  end
endmodule // watchdog_timeout_unit_test
